// *** pkg/interlock_params.svh ***
// Purpose: offsets, field positions and reset values of the interlock block
// Assumes: 32-bit APB data, one word per register
// Notes: definitions only
`ifndef INTERLOCK_PARAMS_SVH
`define INTERLOCK_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define IL_ADDR_W 12
`define IL_OFS_STATE 12'h000
`define IL_OFS_BYPASS 12'h004
`define IL_OFS_EVENT 12'h008
`define IL_OFS_MASK 12'h00C

// ----------------------------------------------------------------
// Interlock bit positions
// ----------------------------------------------------------------
`define IL_NUM 5
`define IL_LOW_POWER 0
`define IL_FW_CLOSED 1
`define IL_TRIPPED 2
`define IL_COLD_TEMP 3
`define IL_HOT_TEMP 4

// ----------------------------------------------------------------
// Bypass bit positions
// ----------------------------------------------------------------
`define BP_NUM 13
`define BP_TRIP_POS_RATE 0
`define BP_TRIP_NEG_RATE 1
`define BP_DWI_POS_RATE 2
`define BP_DWI_NEG_RATE 3
`define BP_TRIP_LOW_MSP 4
`define BP_SEC_LOW_MSP 5
`define BP_DWI_LOW_MSP 6
`define BP_TRIP_LOW_SH 7
`define BP_SEC_LOW_SH 8
`define BP_LTOP_HIGH_PRESS 9
`define BP_SEC_LL_PZR_LVL 10
`define BP_CVC_LL_PZR_LVL 11
`define BP_CIS_LL_PZR_LVL 12

// ----------------------------------------------------------------
// Voting and reset values
// ----------------------------------------------------------------
`define VOTE_CHANNELS 4
`define VOTE_NEEDED 3
`define FW_VALVES 2
`define BREAKERS 2
`define IL_MASK_RESET 5'h00

`endif

// *** pkg/interlock_pkg.sv ***
// Purpose: shared types of the interlock block
// Assumes: widths from interlock_params.svh
// Notes: no constants here, only types
`include "interlock_params.svh"

package interlock_pkg;
    typedef logic [`IL_NUM-1:0] interlock_vec_t;
    typedef logic [`BP_NUM-1:0] bypass_vec_t;
endpackage

// *** pkg/vote_if.sv ***
// Purpose: channel bits into a voter and its verdict back
// Assumes: one voter per interface instance
// Notes: combinational, no clock
`timescale 1ns/1ps

interface vote_if #(parameter int N = 4);
    logic [N-1:0] chan;
    logic vote;
    modport voter (input chan, output vote);
    modport user (output chan, input vote);
endinterface

// *** rtl/vote_m_of_n.sv ***
// Purpose: m-of-n coincidence vote over channel comparison bits
// Assumes: channel bits already synchronised
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps

module vote_m_of_n #(
    parameter int N = 4,
    parameter int M = 3
) (
    // Channels in, verdict out
    vote_if.voter v
);
    localparam int CW = $clog2(N + 1);

    logic [CW-1:0] count;

    // Count tripped channels, then compare with the threshold
    always_comb begin
        count = '0;
        for (int i = 0; i < N; i++) begin
            count = count + CW'(v.chan[i]);
        end
        v.vote = (count >= CW'(M));
    end
endmodule

// *** rtl/protection_interlock_logic.sv ***
// Purpose: interlock evaluation and automatic operating bypasses
// Assumes: comparison and position bits arrive asynchronously from other logic
// Notes: APB slave with status, sticky events, mask and one interrupt
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "interlock_params.svh"

module protection_interlock_logic #(
    parameter int CHANNELS = `VOTE_CHANNELS,
    parameter int NEEDED = `VOTE_NEEDED,
    parameter int FW_VALVES = `FW_VALVES
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Channel comparisons, one bit per channel
    input wire logic [CHANNELS-1:0] power_below_i,
    input wire logic [CHANNELS-1:0] cold_temp_above_i,
    input wire logic [CHANNELS-1:0] hot_temp_below_i,
    // Position indications
    input wire logic [FW_VALVES-1:0] feedwater_isolation_valve_closed_i,
    input wire logic [`BREAKERS-1:0] reactor_trip_breaker_open_i,
    // Interlocks and bypasses to actuation logic
    output logic low_power_interlock_o,
    output logic fw_valve_closed_interlock_o,
    output logic reactor_tripped_interlock_o,
    output logic cold_temp_interlock_o,
    output logic hot_temp_interlock_o,
    output interlock_pkg::bypass_vec_t bypass_o,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`IL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq_o
);
    localparam int PIN_W = 3 * CHANNELS + FW_VALVES + `BREAKERS;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;

    // Asserts at once, releases two edges later to stay clear of recovery
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic [PIN_W-1:0] pin_raw;

    assign pin_raw = {power_below_i, cold_temp_above_i, hot_temp_below_i,
                      feedwater_isolation_valve_closed_i, reactor_trip_breaker_open_i};

    // Two stages; only the second stage feeds the voting logic
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    logic [CHANNELS-1:0] pwr_s, cold_s, hot_s;
    logic [FW_VALVES-1:0] fwv_s;
    logic [`BREAKERS-1:0] brk_s;

    // Unpack the synchronised vector
    assign {pwr_s, cold_s, hot_s, fwv_s, brk_s} = pin_sync_r;

    // ----------------------------------------------------------------
    // Coincidence voting
    // ----------------------------------------------------------------
    vote_if #(.N(CHANNELS)) pwr_vote ();
    vote_if #(.N(CHANNELS)) cold_vote ();
    vote_if #(.N(CHANNELS)) hot_vote ();

    // Channel bits into the three voters
    assign pwr_vote.chan = pwr_s;
    assign cold_vote.chan = cold_s;
    assign hot_vote.chan = hot_s;

    vote_m_of_n #(.N(CHANNELS), .M(NEEDED)) u_vote_power (.v(pwr_vote.voter));
    vote_m_of_n #(.N(CHANNELS), .M(NEEDED)) u_vote_cold (.v(cold_vote.voter));
    vote_m_of_n #(.N(CHANNELS), .M(NEEDED)) u_vote_hot (.v(hot_vote.voter));

    // ----------------------------------------------------------------
    // Interlock and bypass evaluation
    // ----------------------------------------------------------------
    interlock_pkg::interlock_vec_t il_r, il_nxt;
    interlock_pkg::bypass_vec_t bp_r, bp_nxt;

    // Fresh every cycle from current inputs; no latching, so bypasses
    // fall away the same cycle their condition goes false
    always_comb begin
        il_nxt = '0;
        bp_nxt = '0;
        il_nxt[`IL_LOW_POWER] = pwr_vote.vote;
        il_nxt[`IL_FW_CLOSED] = |fwv_s;
        il_nxt[`IL_TRIPPED] = &brk_s;
        il_nxt[`IL_COLD_TEMP] = cold_vote.vote;
        // Tripped qualifies hot temperature in the same evaluation
        il_nxt[`IL_HOT_TEMP] = hot_vote.vote & il_nxt[`IL_TRIPPED];
        bp_nxt[`BP_TRIP_POS_RATE] = il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_TRIP_NEG_RATE] = il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_DWI_POS_RATE] = il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_DWI_NEG_RATE] = il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_TRIP_LOW_MSP] = il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_SEC_LOW_MSP] = il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_DWI_LOW_MSP] = il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_TRIP_LOW_SH] = il_nxt[`IL_FW_CLOSED] & il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_SEC_LOW_SH] = il_nxt[`IL_FW_CLOSED] & il_nxt[`IL_LOW_POWER];
        bp_nxt[`BP_LTOP_HIGH_PRESS] = il_nxt[`IL_COLD_TEMP];
        bp_nxt[`BP_SEC_LL_PZR_LVL] = il_nxt[`IL_HOT_TEMP];
        bp_nxt[`BP_CVC_LL_PZR_LVL] = il_nxt[`IL_HOT_TEMP];
        bp_nxt[`BP_CIS_LL_PZR_LVL] = il_nxt[`IL_HOT_TEMP];
    end

    // Register every cycle; reset leaves all interlocks and bypasses off
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            il_r <= '0;
            bp_r <= '0;
        end else begin
            il_r <= il_nxt;
            bp_r <= bp_nxt;
        end
    end

    // Outputs straight from the registers
    assign low_power_interlock_o = il_r[`IL_LOW_POWER];
    assign fw_valve_closed_interlock_o = il_r[`IL_FW_CLOSED];
    assign reactor_tripped_interlock_o = il_r[`IL_TRIPPED];
    assign cold_temp_interlock_o = il_r[`IL_COLD_TEMP];
    assign hot_temp_interlock_o = il_r[`IL_HOT_TEMP];
    assign bypass_o = bp_r;

    // ----------------------------------------------------------------
    // APB registers, events and interrupt
    // ----------------------------------------------------------------
    interlock_pkg::interlock_vec_t event_r, event_nxt;
    interlock_pkg::interlock_vec_t mask_r, mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic irq_r, irq_nxt;
    logic access, wr_event, wr_mask, hit;
    interlock_pkg::interlock_vec_t change;

    // Zero-wait slave: the access phase completes on its first edge
    assign access = psel & penable;
    assign hit = (paddr == `IL_OFS_STATE) || (paddr == `IL_OFS_BYPASS) ||
                 (paddr == `IL_OFS_EVENT) || (paddr == `IL_OFS_MASK);
    assign wr_event = access & pwrite & (paddr == `IL_OFS_EVENT);
    assign wr_mask = access & pwrite & (paddr == `IL_OFS_MASK);
    // Any edge of an interlock counts as an event
    assign change = il_nxt ^ il_r;

    // Write one clears, but a change in the same cycle wins
    always_comb begin
        event_nxt = event_r;
        mask_nxt = mask_r;
        if (wr_event) begin
            event_nxt = event_r & ~pwdata[`IL_NUM-1:0];
        end
        event_nxt = event_nxt | change;
        if (wr_mask) begin
            mask_nxt = pwdata[`IL_NUM-1:0];
        end
        irq_nxt = |(event_nxt & mask_nxt);
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            pslverr_nxt = !hit;
            if (!pwrite) begin
                case (paddr)
                    `IL_OFS_STATE: prdata_nxt = {{(32-`IL_NUM){1'b0}}, il_r};
                    `IL_OFS_BYPASS: prdata_nxt = {{(32-`BP_NUM){1'b0}}, bp_r};
                    `IL_OFS_EVENT: prdata_nxt = {{(32-`IL_NUM){1'b0}}, event_r};
                    `IL_OFS_MASK: prdata_nxt = {{(32-`IL_NUM){1'b0}}, mask_r};
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end else if (access) begin
            prdata_nxt = prdata_r;
            pslverr_nxt = pslverr_r;
        end
    end

    // Bus and interrupt state
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            event_r <= '0;
            mask_r <= `IL_MASK_RESET;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            event_r <= event_nxt;
            mask_r <= mask_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Ready is constant high once out of reset; data is set up in the
    // setup phase so it stands registered during the access phase
    logic pready_r;
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign pready = pready_r;
    assign irq_o = irq_r;
endmodule

// *** test/interlock_sva.sv ***
// Purpose: port-level checks of the interlock votes and bypasses
// Assumes: inputs held steady eight edges mean outputs have settled
// Notes: bound into the top module at the foot of this file
`timescale 1ns/1ps

module interlock_sva #(
    parameter int CHANNELS = 4,
    parameter int NEEDED = 3,
    parameter int FW_VALVES = 2
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Pins in
    input wire logic [CHANNELS-1:0] power_below_i,
    input wire logic [CHANNELS-1:0] cold_temp_above_i,
    input wire logic [CHANNELS-1:0] hot_temp_below_i,
    input wire logic [FW_VALVES-1:0] feedwater_isolation_valve_closed_i,
    input wire logic [1:0] reactor_trip_breaker_open_i,
    // Pins out
    input wire logic low_power_interlock_o,
    input wire logic fw_valve_closed_interlock_o,
    input wire logic reactor_tripped_interlock_o,
    input wire logic cold_temp_interlock_o,
    input wire logic hot_temp_interlock_o,
    input wire interlock_pkg::bypass_vec_t bypass_o,
    input wire logic pready
);
    logic [3*CHANNELS+FW_VALVES+1:0] ins;
    logic [3*CHANNELS+FW_VALVES+1:0] prev_r;
    logic [3:0] calm_r;
    logic [17:0] outs;
    logic settled;
    assign ins = {power_below_i, cold_temp_above_i, hot_temp_below_i,
        feedwater_isolation_valve_closed_i, reactor_trip_breaker_open_i};
    assign outs = {hot_temp_interlock_o, cold_temp_interlock_o, reactor_tripped_interlock_o,
        fw_valve_closed_interlock_o, low_power_interlock_o, bypass_o};
    // --------------------------------------------------
    // Settle counter: sync stages hide changes for a while
    // --------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_r <= '0;
            calm_r <= 4'h0;
        end else begin
            prev_r <= ins;
            calm_r <= (ins != prev_r) ? 4'h0 : ((calm_r == 4'hF) ? calm_r : calm_r + 4'h1);
        end
    end
    // Quiet long enough and no fresh change on this very edge
    assign settled = (calm_r >= 4'h8) && (ins == prev_r);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_low_power_vote: assert property (settled |-> low_power_interlock_o ==
        ($countones(power_below_i) >= NEEDED)) else $error("low power vote wrong");
    a_fw_any_closed: assert property (settled |-> fw_valve_closed_interlock_o ==
        (|feedwater_isolation_valve_closed_i)) else $error("valve closed wrong");
    a_trip_both_open: assert property (settled |-> reactor_tripped_interlock_o ==
        (&reactor_trip_breaker_open_i)) else $error("tripped wrong");
    a_cold_vote: assert property (settled |-> cold_temp_interlock_o ==
        ($countones(cold_temp_above_i) >= NEEDED)) else $error("cold vote wrong");
    a_hot_vote_tripped: assert property (settled |-> hot_temp_interlock_o ==
        ($countones(hot_temp_below_i) >= NEEDED && (&reactor_trip_breaker_open_i)))
        else $error("hot vote wrong");
    a_low_power_bypass: assert property (bypass_o[6:0] == {7{low_power_interlock_o}})
        else $error("low power bypass wrong");
    a_superheat_bypass: assert property (bypass_o[8:7] ==
        {2{fw_valve_closed_interlock_o & low_power_interlock_o}}) else $error("superheat wrong");
    a_ltop_bypass: assert property (bypass_o[9] == cold_temp_interlock_o)
        else $error("overpressure bypass wrong");
    a_level_bypass: assert property (bypass_o[12:10] == {3{hot_temp_interlock_o}})
        else $error("level bypass wrong");
    a_outputs_lag: assert property (calm_r >= 4'h8 && ins != prev_r |=> $stable(outs) [*2])
        else $error("outputs moved too soon");
    a_ready_held: assert property (pready |=> pready) else $error("pready dropped");
    c_low_power: cover property (low_power_interlock_o && bypass_o[0]);
    c_hot: cover property (hot_temp_interlock_o);
    c_superheat: cover property (bypass_o[7]);
endmodule

bind protection_interlock_logic interlock_sva #(.CHANNELS(CHANNELS), .NEEDED(NEEDED),
    .FW_VALVES(FW_VALVES)) u_sva (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .power_below_i(power_below_i),
    .cold_temp_above_i(cold_temp_above_i), .hot_temp_below_i(hot_temp_below_i),
    .feedwater_isolation_valve_closed_i(feedwater_isolation_valve_closed_i),
    .reactor_trip_breaker_open_i(reactor_trip_breaker_open_i),
    .low_power_interlock_o(low_power_interlock_o),
    .fw_valve_closed_interlock_o(fw_valve_closed_interlock_o),
    .reactor_tripped_interlock_o(reactor_tripped_interlock_o),
    .cold_temp_interlock_o(cold_temp_interlock_o), .hot_temp_interlock_o(hot_temp_interlock_o),
    .bypass_o(bypass_o), .pready(pready));

// *** test/channel_model.sv ***
// Purpose: stand-in for the channel comparison and position sensing logic
// Assumes: the bench gives a packed pattern of all comparison bits
// Notes: pins change just after a rising edge, like real clocked logic
`timescale 1ns/1ps

module channel_model (
    // Clock and requested pattern
    input wire logic ref_clk_i,
    input wire logic [15:0] plan_i,
    // Comparison and position bits
    output logic [3:0] power_below_o = 4'h0,
    output logic [3:0] cold_temp_above_o = 4'h0,
    output logic [3:0] hot_temp_below_o = 4'h0,
    output logic [1:0] valve_closed_o = 2'h0,
    output logic [1:0] breaker_open_o = 2'h0
);
    // Registered so no pin moves on the sampling edge itself
    always_ff @(posedge ref_clk_i) begin
        {power_below_o, cold_temp_above_o, hot_temp_below_o} <= plan_i[15:4];
        {valve_closed_o, breaker_open_o} <= plan_i[3:0];
    end
endmodule

// *** test/protection_interlock_logic_bench.sv ***
// Purpose: random and corner pin patterns, APB register traffic, interrupt
// Assumes: zero-wait APB slave, outputs settled six edges after a change
// Notes: pin-pattern expectations come from expect_of; the first register checks use fixed values
`timescale 1ns/1ps
`include "interlock_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %0t mismatch", $time); end end

module protection_interlock_logic_bench;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] plan = 16'h0, v;
    logic [3:0] pb, ct, ht;
    logic [1:0] fw, br;
    logic lp, fc, trp, cd, hot, pready, pslverr, irq, err;
    logic [4:0] il_prev = 5'h00, msk;
    logic [17:0] e;
    interlock_pkg::bypass_vec_t byp;
    int num_errors = 0, n_tests = 0, cyc = 0;
    logic [31:0] seed = 32'h3F3B6881;
    // Exactly-three votes, two-of-four misses, one breaker only
    logic [15:0] corner [7] = '{16'h7000, 16'h3000, 16'hE004, 16'h0B01, 16'h00E1,
        16'h00E3, 16'h0002};
    channel_model u_src (.ref_clk_i(ref_clk_i), .plan_i(plan), .power_below_o(pb),
        .cold_temp_above_o(ct), .hot_temp_below_o(ht), .valve_closed_o(fw), .breaker_open_o(br));
    protection_interlock_logic u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .power_below_i(pb), .cold_temp_above_i(ct), .hot_temp_below_i(ht),
        .feedwater_isolation_valve_closed_i(fw), .reactor_trip_breaker_open_i(br),
        .low_power_interlock_o(lp), .fw_valve_closed_interlock_o(fc),
        .reactor_tripped_interlock_o(trp), .cold_temp_interlock_o(cd),
        .hot_temp_interlock_o(hot), .bypass_o(byp), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_o(irq));
    // --------------------------------------------------
    // Expected interlocks {hot,cold,tripped,fw,low} and bypasses
    // --------------------------------------------------
    function automatic logic [17:0] expect_of(input logic [15:0] p);
        logic l, f, t, c, h;
        l = $countones(p[15:12]) >= 3;
        f = |p[3:2];
        t = &p[1:0];
        c = $countones(p[11:8]) >= 3;
        h = ($countones(p[7:4]) >= 3) && t;
        return {h, c, t, f, l, {3{h}}, c, {2{f & l}}, {7{l}}};
    endfunction
    // One APB transfer; waits for pready, only the hang guard bounds the wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // Hang guard, far above the expected thousand or so cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        apb(1'b0, `IL_OFS_MASK, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, `IL_OFS_MASK, 32'h1F);
        apb(1'b0, `IL_OFS_MASK, 32'h0);
        `CHK(rd, 32'h1F)
        $display("apb test done");
        for (int i = 0; i < 47; i++) begin
            v = (i < 7) ? corner[i] : 16'($random(seed));
            msk = 5'($random(seed));
            apb(1'b1, `IL_OFS_MASK, {27'h0, msk});
            apb(1'b1, `IL_OFS_EVENT, 32'h1F);
            plan <= v;
            repeat (6) @(posedge ref_clk_i);
            e = expect_of(v);
            `CHK({hot, cd, trp, fc, lp}, e[17:13])
            `CHK(byp, e[12:0])
            `CHK(irq, |((il_prev ^ e[17:13]) & msk))
            apb(1'b1, `IL_OFS_STATE, 32'h1F);
            apb(1'b0, `IL_OFS_STATE, 32'h0);
            `CHK(rd, {27'h0, e[17:13]})
            apb(1'b0, `IL_OFS_EVENT, 32'h0);
            `CHK(rd, {27'h0, il_prev ^ e[17:13]})
            il_prev = e[17:13];
        end
        $display("vector test done");
        report_and_stop;
    end
endmodule
